// ==== periodic_timer_pkg.sv ====
// Shared constants and carriers for the periodic timer register block.
// Assumes one clock domain; pins are synchronised inside the block.
package periodic_timer_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int CNT_W = 10;           // Counter and compare width
    localparam int BYTE_W = 8;           // Register data width
    localparam int ADDR_W = 3;           // Register address width
    localparam int DIV_W = 6;            // Internal prescaler width

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [2:0] ADDR_CTL0 = 3'h0;     // timer_control_0
    localparam logic [2:0] ADDR_CTL1 = 3'h1;     // timer_control_1
    localparam logic [2:0] ADDR_CNT_LO = 3'h2;   // count_value_low
    localparam logic [2:0] ADDR_CNT_HI = 3'h3;   // count_value_high
    localparam logic [2:0] ADDR_CMPA_LO = 3'h4;  // compare_a_low
    localparam logic [2:0] ADDR_CMPA_HI = 3'h5;  // compare_a_high
    localparam logic [2:0] ADDR_PER_LO = 3'h6;   // period_compare_low
    localparam logic [2:0] ADDR_PER_HI = 3'h7;   // period_compare_high

    // ************************************************************
    // Field positions, masks and reset values
    // ************************************************************
    localparam int CTL0_HOLD = 7;        // counter_hold_ctl
    localparam int CTL0_CLK_LSB = 4;     // count_clock_sel, 3 bits
    localparam int CTL0_ON = 3;          // counter_on_ctl
    localparam int CTL1_MODE_LSB = 6;    // op_mode_sel, 2 bits
    localparam int CTL1_PIN_LSB = 4;     // pin_function_sel, 2 bits
    localparam int CTL1_LVL = 3;         // output_level_ctl
    localparam int CTL1_INV = 2;         // output_invert_ctl
    localparam int CTL1_CAPSRC = 1;      // capture_source_sel
    localparam int CTL1_CLRSEL = 0;      // counter_clear_sel
    localparam logic [7:0] CTL0_MASK = 8'hF8;    // Implemented control 0 bits
    localparam logic [7:0] CTL0_RST = 8'h00;
    localparam logic [7:0] CTL1_RST = 8'h00;

    // ************************************************************
    // Encodings
    // ************************************************************
    localparam logic [2:0] CLK_SYS_DIV4 = 3'h0;
    localparam logic [2:0] CLK_SYS = 3'h1;
    localparam logic [2:0] CLK_HIGH_DIV16 = 3'h2;
    localparam logic [2:0] CLK_HIGH_DIV64 = 3'h3;
    localparam logic [2:0] CLK_SUB_A = 3'h4;
    localparam logic [2:0] CLK_SUB_B = 3'h5;
    localparam logic [2:0] CLK_EXT_RISE = 3'h6;
    localparam logic [2:0] CLK_EXT_FALL = 3'h7;
    localparam logic [5:0] DIV4_MASK = 6'h03;
    localparam logic [5:0] DIV16_MASK = 6'h0F;
    localparam logic [5:0] DIV64_MASK = 6'h3F;

    typedef enum logic [1:0] {
        MODE_COMPARE = 2'h0,
        MODE_CAPTURE = 2'h1,
        MODE_PWM = 2'h2,
        MODE_TIMER = 2'h3
    } op_mode_t;

    localparam logic [1:0] PIN_NONE = 2'h0;      // Compare: keep, PWM: inactive
    localparam logic [1:0] PIN_LOW = 2'h1;       // Compare: low, PWM: active
    localparam logic [1:0] PIN_HIGH = 2'h2;      // Compare: high, PWM: waveform
    localparam logic [1:0] PIN_TOGGLE = 2'h3;    // Compare: toggle, PWM: pulse
    localparam logic [1:0] CAP_RISE = 2'h0;
    localparam logic [1:0] CAP_FALL = 2'h1;
    localparam logic [1:0] CAP_BOTH = 2'h2;

    // ************************************************************
    // Carriers and module state
    // ************************************************************
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic last;
    } sync_state_t;

    typedef struct packed {
        logic [5:0] div;
        logic tick;
    } prescale_state_t;

    typedef struct packed {
        logic [7:0] ctl0;
        logic [7:0] ctl1;
        logic [9:0] count;
        logic [9:0] cmpA;
        logic [9:0] cmpP;
        logic [7:0] byteBuf;
        logic [7:0] rdData;
        logic onLast;
        logic outLevel;
        logic pinOut;
        logic pinEn;
        logic matchA;
        logic matchP;
    } timer_state_t;

endpackage

// ==== sync_edge_detect.sv ====
// Two-flop synchroniser with edge pulses for one asynchronous pin.
// Assumes the pin may change at any time relative to clk.
`timescale 1ns/1ps
`default_nettype none
module sync_edge_detect
    import periodic_timer_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pinIn,
    output logic level,
    output logic rise,
    output logic fall
);
    // ************************************************************
    // State
    // ************************************************************
    sync_state_t s;       // Present state
    sync_state_t next_s;  // Next state

    // Shift the pin through two flops, then keep one more for edges
    always_comb begin
        next_s = s;
        next_s.sync1 = pinIn;
        next_s.sync2 = s.sync1;
        next_s.last = s.sync2;
    end

    // Register the state, synchronous reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Only the second flop and later feed the outputs
    assign level = s.sync2;
    assign rise = s.sync2 & ~s.last;
    assign fall = ~s.sync2 & s.last;
endmodule
`default_nettype wire

// ==== count_clock_gen.sv ====
// Count clock selection: produces a one-cycle count tick.
// Assumes sub clock and external edges arrive already synchronised.
`timescale 1ns/1ps
`default_nettype none
module count_clock_gen
    import periodic_timer_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] clkSel,
    input wire logic subRise,
    input wire logic extRise,
    input wire logic extFall,
    output logic tick
);
    // ************************************************************
    // State
    // ************************************************************
    prescale_state_t s;       // Present state
    prescale_state_t next_s;  // Next state

    // Free running divider; high clock is taken as the system clock
    always_comb begin
        next_s = s;
        next_s.div = s.div + 6'h01;
        case (clkSel)
            CLK_SYS_DIV4: next_s.tick = (s.div & DIV4_MASK) == DIV4_MASK;
            CLK_SYS: next_s.tick = 1'b1;
            CLK_HIGH_DIV16: next_s.tick = (s.div & DIV16_MASK) == DIV16_MASK;
            CLK_HIGH_DIV64: next_s.tick = (s.div & DIV64_MASK) == DIV64_MASK;
            CLK_SUB_A, CLK_SUB_B: next_s.tick = subRise;
            CLK_EXT_RISE: next_s.tick = extRise;
            CLK_EXT_FALL: next_s.tick = extFall;
            default: next_s.tick = 1'b0;
        endcase
    end

    // Register the state, synchronous reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;
endmodule
`default_nettype wire

// ==== periodic_timer.sv ====
// Periodic timer register set with its 10-bit counter and output pin.
// Assumes a plain register port on clk and asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module periodic_timer
    import periodic_timer_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire reg_req_t regReq,
    output logic [7:0] rdData,
    input wire logic extCountPin,
    input wire logic capturePin,
    input wire logic subClkPin,
    output logic timerOut,
    output logic timerOutEn,
    output logic matchA,
    output logic matchP
);
    // ************************************************************
    // State and decoded controls
    // ************************************************************
    timer_state_t s;         // Present state
    timer_state_t next_s;    // Next state
    logic tick;              // One-cycle count clock
    logic extRise;           // External count pin rising edge
    logic extFall;           // External count pin falling edge
    logic capRise;           // Capture pin rising edge
    logic capFall;           // Capture pin falling edge
    logic subRise;           // Sub clock rising edge
    logic hold;              // Counter held
    logic onCtl;             // Counter switched on
    logic onRise;            // Counter-on low to high this cycle
    logic [2:0] clkSel;      // Count clock selection
    op_mode_t mode;          // Operating mode
    logic [1:0] pinFn;       // Pin function selection
    logic lvl;               // Output level bit
    logic inv;               // Output invert bit
    logic clrOnA;            // Clear on comparator A
    logic [9:0] nextCount;   // Counter plus one, wraps at overflow
    logic hitA;              // Comparator A reached
    logic hitP;              // Comparator P reached
    logic clearNow;          // Counter clears instead of advancing
    logic selRise;           // Rising edge of the capture source
    logic selFall;           // Falling edge of the capture source
    logic capEdge;           // Selected capture event

    assign hold = s.ctl0[CTL0_HOLD];
    assign onCtl = s.ctl0[CTL0_ON];
    assign clkSel = s.ctl0[CTL0_CLK_LSB +: 3];
    assign mode = op_mode_t'(s.ctl1[CTL1_MODE_LSB +: 2]);
    assign pinFn = s.ctl1[CTL1_PIN_LSB +: 2];
    assign lvl = s.ctl1[CTL1_LVL];
    assign inv = s.ctl1[CTL1_INV];
    assign clrOnA = s.ctl1[CTL1_CLRSEL];

    // ************************************************************
    // Pin synchronisers and count clock
    // ************************************************************
    sync_edge_detect extSync (
        .clk(clk),
        .rst_n(rst_n),
        .pinIn(extCountPin),
        .level(),
        .rise(extRise),
        .fall(extFall)
    );

    sync_edge_detect capSync (
        .clk(clk),
        .rst_n(rst_n),
        .pinIn(capturePin),
        .level(),
        .rise(capRise),
        .fall(capFall)
    );

    sync_edge_detect subSync (
        .clk(clk),
        .rst_n(rst_n),
        .pinIn(subClkPin),
        .level(),
        .rise(subRise),
        .fall()
    );

    count_clock_gen clockGen (
        .clk(clk),
        .rst_n(rst_n),
        .clkSel(clkSel),
        .subRise(subRise),
        .extRise(extRise),
        .extFall(extFall),
        .tick(tick)
    );

    // ************************************************************
    // Comparators and capture selection
    // ************************************************************
    // Matches are judged on the value the counter is about to take
    always_comb begin
        onRise = onCtl & ~s.onLast;
        nextCount = s.count + 10'h001;
        // A zero compare A never matches; the counter then overflows
        hitA = (nextCount == s.cmpA) && (s.cmpA != 10'h000);
        // A zero period compare matches at the wrap
        hitP = (nextCount == s.cmpP);
        if ((mode == MODE_COMPARE || mode == MODE_TIMER) && clrOnA) begin
            clearNow = hitA;
        end else begin
            clearNow = hitP;
        end
        // Capture source is the capture pin or the external count pin
        if (s.ctl1[CTL1_CAPSRC]) begin
            selRise = extRise;
            selFall = extFall;
        end else begin
            selRise = capRise;
            selFall = capFall;
        end
        case (pinFn)
            CAP_RISE: capEdge = selRise;
            CAP_FALL: capEdge = selFall;
            CAP_BOTH: capEdge = selRise | selFall;
            default: capEdge = 1'b0;
        endcase
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_s = s;
        next_s.onLast = onCtl;
        next_s.matchA = 1'b0;
        next_s.matchP = 1'b0;
        next_s.rdData = 8'h00;

        // Counter: restart on switch-on, advance only while on and free
        if (onRise) begin
            next_s.count = 10'h000;
            if (mode != MODE_CAPTURE && mode != MODE_TIMER) begin
                // Initial or single pulse level from the level bit
                next_s.outLevel = lvl;
            end
        end else if (onCtl && !hold && tick) begin
            next_s.count = clearNow ? 10'h000 : nextCount;
            next_s.matchA = hitA && mode != MODE_CAPTURE;
            // No period flag while compare A clears the counter
            next_s.matchP = hitP && !(clrOnA && mode != MODE_PWM
                && mode != MODE_CAPTURE);
            if (mode == MODE_COMPARE && hitA) begin
                // Equal levels leave the pin as it stands
                case (pinFn)
                    PIN_LOW: next_s.outLevel = 1'b0;
                    PIN_HIGH: next_s.outLevel = 1'b1;
                    PIN_TOGGLE: next_s.outLevel = ~s.outLevel;
                    default: next_s.outLevel = s.outLevel;
                endcase
            end
            if (mode == MODE_PWM && pinFn == PIN_TOGGLE && hitA) begin
                // Single pulse ends at the compare A match
                next_s.outLevel = ~lvl;
            end
        end

        // PWM forced states and waveform, relative to the active level
        if (mode == MODE_PWM && onCtl) begin
            case (pinFn)
                PIN_NONE: next_s.outLevel = ~lvl;
                PIN_LOW: next_s.outLevel = lvl;
                PIN_HIGH: next_s.outLevel = (next_s.count < s.cmpA) ? lvl : ~lvl;
                default: next_s.outLevel = next_s.outLevel;
            endcase
        end

        // Capture copies the count into compare A
        if (mode == MODE_CAPTURE && onCtl && capEdge) begin
            next_s.cmpA = s.count;
        end

        // Register writes
        if (regReq.wr) begin
            case (regReq.addr)
                ADDR_CTL0: next_s.ctl0 = regReq.wdata & CTL0_MASK;
                ADDR_CTL1: next_s.ctl1 = regReq.wdata;
                ADDR_CMPA_LO, ADDR_PER_LO: next_s.byteBuf = regReq.wdata;
                ADDR_CMPA_HI: next_s.cmpA = {regReq.wdata[1:0], s.byteBuf};
                ADDR_PER_HI: next_s.cmpP = {regReq.wdata[1:0], s.byteBuf};
                // Count pair ignores writes
                default: ;
            endcase
        end

        // Register reads, answered in the next cycle
        if (regReq.rd) begin
            case (regReq.addr)
                ADDR_CTL0: next_s.rdData = s.ctl0;
                ADDR_CTL1: next_s.rdData = s.ctl1;
                ADDR_CNT_LO, ADDR_CMPA_LO, ADDR_PER_LO: next_s.rdData = s.byteBuf;
                ADDR_CNT_HI: begin
                    next_s.rdData = {6'h00, s.count[9:8]};
                    next_s.byteBuf = s.count[7:0];
                end
                ADDR_CMPA_HI: begin
                    next_s.rdData = {6'h00, s.cmpA[9:8]};
                    next_s.byteBuf = s.cmpA[7:0];
                end
                ADDR_PER_HI: begin
                    next_s.rdData = {6'h00, s.cmpP[9:8]};
                    next_s.byteBuf = s.cmpP[7:0];
                end
                default: next_s.rdData = 8'h00;
            endcase
        end

        // Pin: inverted if asked, released in timer and capture modes
        next_s.pinEn = (mode != MODE_TIMER) && (mode != MODE_CAPTURE);
        next_s.pinOut = next_s.pinEn & (next_s.outLevel ^ inv);
    end

    // ************************************************************
    // State register
    // ************************************************************
    // Synchronous reset; control registers take their reset values
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
            s.ctl0 <= CTL0_RST;
            s.ctl1 <= CTL1_RST;
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign rdData = s.rdData;
    assign timerOut = s.pinOut;
    assign timerOutEn = s.pinEn;
    assign matchA = s.matchA;
    assign matchP = s.matchP;
endmodule
`default_nettype wire

// ==== periodic_timer_chk.sv ====
// Concurrent checks on the periodic timer ports.
// Assumes it is bound to periodic_timer and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module periodic_timer_chk
    import periodic_timer_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire reg_req_t regReq,
    input wire logic [7:0] rdData,
    input wire logic timerOut,
    input wire logic timerOutEn,
    input wire logic matchA
);
    // ************************************************************
    // Shadow of the control bits
    // ************************************************************
    logic [7:0] ctl1Seen; // Last value written to control 1
    logic onSeen; // Last counter-on bit written
    logic [1:0] mode; // Mode field of the shadow
    logic lvl; // Expected initial pin level
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Track control writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl1Seen <= 8'h00;
            onSeen <= 1'b0;
        end else if (regReq.wr && regReq.addr == ADDR_CTL1) begin
            ctl1Seen <= regReq.wdata;
        end else if (regReq.wr && regReq.addr == ADDR_CTL0) begin
            onSeen <= regReq.wdata[CTL0_ON];
        end
    end
    assign mode = ctl1Seen[7:6];
    assign lvl = ctl1Seen[CTL1_LVL] ^ ctl1Seen[CTL1_INV];
    // ************************************************************
    // Assertions
    // ************************************************************
    AST_RD_QUIET: assert property (!$past(regReq.rd) |-> rdData == 8'h00)
        else $error("read data not zero");
    AST_CTL0_UNUSED: assert property ($past(regReq.rd) && $past(regReq.addr) == ADDR_CTL0
        |-> rdData[2:0] == 3'h0) else $error("control 0 low bits not zero");
    AST_HIGH_UNUSED: assert property ($past(regReq.rd) && $past(regReq.addr[0])
        && $past(regReq.addr) != ADDR_CTL1 |-> rdData[7:2] == 6'h00)
        else $error("high byte upper bits not zero");
    AST_TIMER_NO_PIN: assert property ((mode == MODE_TIMER) [*2] |-> !timerOutEn)
        else $error("output driven in timer mode");
    AST_CAPTURE_NO_MATCH: assert property ((mode == MODE_CAPTURE) [*2] |-> !matchA)
        else $error("compare A match in capture mode");
    AST_DRIVE_EN: assert property ((rst_n && mode inside {MODE_COMPARE, MODE_PWM}) [*2]
        |-> timerOutEn) else $error("output not driven");
    AST_OUT_GATED: assert property (!timerOutEn |-> !timerOut)
        else $error("output high while not driven");
    AST_MATCH_PULSE: assert property (matchA |=> !matchA)
        else $error("match A too long");
    AST_ON_LEVEL: assert property ($rose(onSeen) && mode == MODE_COMPARE
        |-> ##[1:3] timerOut == lvl) else $error("initial level not applied");
    AST_PULSE_LEVEL: assert property ($rose(onSeen) && mode == MODE_PWM
        && ctl1Seen[5:4] == PIN_TOGGLE |-> ##[1:3] timerOut == lvl)
        else $error("single pulse start level wrong");
    // Main scenarios reached
    COV_MATCH: cover property (matchA);
    COV_EN_OFF: cover property ($fell(timerOutEn));
    COV_ON_RISE: cover property ($rose(onSeen));
endmodule
`default_nettype wire

// ==== pin_partner.sv ====
// Far side pin drivers: external count pin, capture pin, sub clock.
// Assumes the bench calls pulse; pins rest low between pulses.
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
    input wire logic clk,
    output logic extCountPin,
    output logic capturePin,
    output logic subClkPin
);
    // ************************************************************
    // Pulse generator
    // ************************************************************
    initial begin
        extCountPin = 1'b0;
        capturePin = 1'b0;
        subClkPin = 1'b0;
    end
    // Each pulse waits four cycles low, then drives four cycles high
    task automatic pulse(input logic [1:0] pinSel, input int n);
        for (int i = 0; i < n; i++) begin
            repeat (4) @(posedge clk);
            case (pinSel)
                2'h0: extCountPin <= 1'b1;
                2'h1: capturePin <= 1'b1;
                default: subClkPin <= 1'b1;
            endcase
            repeat (4) @(posedge clk);
            extCountPin <= 1'b0;
            capturePin <= 1'b0;
            subClkPin <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ==== periodic_timer_tb.sv ====
// Self-checking bench for the periodic timer register block.
// Assumes reads answer one cycle later, no waits.
`timescale 1ns/1ps
`default_nettype none
module periodic_timer_tb;
    import periodic_timer_pkg::*;
    // ************************************************************
    // Signals
    // ************************************************************
    logic clk;
    logic rst_n;
    reg_req_t regReq; // Register request from the bench
    logic [7:0] rdData;
    logic extCountPin, capturePin, subClkPin; // Far side pins
    logic timerOut, timerOutEn, matchA, matchP;
    int errorCnt = 0; // Mismatches seen
    int samplesChecked = 0; // Comparisons made
    periodic_timer i_dut (.clk(clk), .rst_n(rst_n), .regReq(regReq), .rdData(rdData),
        .extCountPin(extCountPin), .capturePin(capturePin), .subClkPin(subClkPin),
        .timerOut(timerOut), .timerOutEn(timerOutEn), .matchA(matchA), .matchP(matchP));
    pin_partner i_far (.clk(clk), .extCountPin(extCountPin), .capturePin(capturePin),
        .subClkPin(subClkPin));
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ************************************************************
    // Bus and compare tasks
    // ************************************************************
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk) regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk) regReq.wr <= 1'b0;
    endtask
    // Read data stand in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk) regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk) regReq.rd <= 1'b0;
        #1 d = rdData;
    endtask
    // High byte first, low byte from the buffer
    task automatic rd10(input logic [2:0] hi, output logic [9:0] v);
        logic [7:0] h, l;
        rd(hi, h);
        rd(hi - 3'h1, l);
        v = {h[1:0], l};
    endtask
    task automatic wr10(input logic [2:0] lo, input logic [9:0] v);
        wr(lo, v[7:0]);
        wr(lo + 3'h1, {6'h00, v[9:8]});
    endtask
    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] seen);
        samplesChecked++;
        if (seen !== exp) begin
            errorCnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    // Reset values, unused bits, read-only count, buffered pairs
    task automatic test_regs();
        logic [7:0] d;
        logic [9:0] v;
        rd(ADDR_CTL0, d);
        chk("ctl0 reset", 10'(CTL0_RST), 10'(d));
        rd(ADDR_CTL1, d);
        chk("ctl1 reset", 10'(CTL1_RST), 10'(d));
        wr(ADDR_CTL0, 8'h07);
        rd(ADDR_CTL0, d);
        chk("ctl0 unused", 10'h000, 10'(d));
        wr(ADDR_CTL0, 8'hF0);
        rd(ADDR_CTL0, d);
        chk("ctl0 used", 10'h0F0, 10'(d));
        wr(ADDR_CTL0, 8'h00);
        wr10(ADDR_CNT_LO, 10'h3FF);
        rd10(ADDR_CNT_HI, v);
        chk("count read only", 10'h000, v);
        wr10(ADDR_CMPA_LO, 10'h2A5);
        wr10(ADDR_PER_LO, 10'h15A);
        wr(ADDR_CMPA_LO, 8'h11);
        rd10(ADDR_CMPA_HI, v);
        chk("compare a pair", 10'h2A5, v);
        rd10(ADDR_PER_HI, v);
        chk("period pair", 10'h15A, v);
        $display("test_regs done");
    endtask
    // Counter on, hold and off
    task automatic test_hold();
        logic [9:0] v1, v2, v3;
        wr10(ADDR_PER_LO, 10'h000);
        wr(ADDR_CTL1, 8'hC0);
        wr(ADDR_CTL0, 8'h18);
        repeat (30) @(posedge clk);
        wr(ADDR_CTL0, 8'h98);
        rd10(ADDR_CNT_HI, v1);
        repeat (20) @(posedge clk);
        rd10(ADDR_CNT_HI, v2);
        chk("count held", v1, v2);
        wr(ADDR_CTL0, 8'h18);
        repeat (10) @(posedge clk);
        wr(ADDR_CTL0, 8'h10);
        rd10(ADDR_CNT_HI, v2);
        chk("count resumed", 10'h001, {9'h000, v2 > v1 && v1 > 10'h000});
        repeat (20) @(posedge clk);
        rd10(ADDR_CNT_HI, v3);
        chk("count kept off", v2, v3);
        wr(ADDR_CTL0, 8'h88);
        rd10(ADDR_CNT_HI, v1);
        chk("count on rise", 10'h000, v1);
        wr(ADDR_CTL0, 8'h08);
        repeat (400) @(posedge clk);
        wr(ADDR_CTL0, 8'h88);
        rd10(ADDR_CNT_HI, v3);
        chk("quarter rate", 10'h001, {9'h000, v3 >= 10'd98 && v3 <= 10'd102});
        $display("test_hold done");
    endtask
    // Sub clock and external pin edges as count clock
    task automatic test_clksel();
        logic [2:0] sel[4] = '{CLK_SUB_A, CLK_SUB_B, CLK_EXT_RISE, CLK_EXT_FALL};
        logic [1:0] pin[4] = '{2'h2, 2'h2, 2'h0, 2'h0};
        logic [9:0] v;
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CTL0, 8'h00);
            wr(ADDR_CTL0, {1'b0, sel[i], 4'h8});
            i_far.pulse(pin[i], 5);
            repeat (8) @(posedge clk);
            rd10(ADDR_CNT_HI, v);
            chk("pin clock count", 10'd5, v);
        end
        $display("test_clksel done");
    endtask
    // Output pin in compare, PWM and timer modes, per pin field and level bit
    task automatic test_output();
        logic [7:0] c[10] = '{8'h18, 8'h28, 8'h30, 8'h08, 8'h98, 8'h88, 8'h90, 8'hA8,
            8'hB8, 8'hC8};
        logic [2:0] e[10] = '{3'h6, 3'h7, 3'h5, 3'h7, 3'h7, 3'h4, 3'h4, 3'h6, 3'h6, 3'h0};
        wr10(ADDR_CMPA_LO, 10'd5);
        for (int i = 0; i < 10; i++) begin
            wr(ADDR_CTL0, 8'h00);
            wr(ADDR_CTL1, c[i]);
            wr(ADDR_CTL0, 8'h18);
            repeat (3) @(posedge clk);
            #1 chk("output enable", 10'(e[i][2]), 10'(timerOutEn));
            chk("output start", 10'(e[i][1]), 10'(timerOut));
            chk("period match idle", 10'h000, 10'(matchP));
            repeat (20) @(posedge clk);
            #1 chk("output after match", 10'(e[i][0]), 10'(timerOut));
        end
        $display("test_output done");
    endtask
    // Capture edges copy the count into compare A
    task automatic test_capture();
        logic [7:0] c[4] = '{8'h40, 8'h70, 8'h50, 8'h60};
        int n[4] = '{3, 1, 2, 4};
        logic [9:0] e[4] = '{10'd3, 10'd3, 10'd2, 10'd4};
        logic [9:0] v;
        wr10(ADDR_CMPA_LO, 10'h3FF);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CTL0, 8'h00);
            wr(ADDR_CTL1, c[i]);
            wr(ADDR_CTL0, 8'h48);
            i_far.pulse(2'h2, n[i]);
            i_far.pulse(2'h1, 1);
            repeat (8) @(posedge clk);
            rd10(ADDR_CMPA_HI, v);
            chk("captured count", e[i], v);
        end
        $display("test_capture done");
    endtask
    // ************************************************************
    // Sequence, watchdog and verdict
    // ************************************************************
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
        if (errorCnt == 0 && samplesChecked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        regReq = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        test_regs();
        test_hold();
        test_clksel();
        test_capture();
        test_output();
        end_sim();
    end
    // Watchdog
    initial begin
        #100000;
        errorCnt++;
        end_sim();
    end
endmodule
bind periodic_timer periodic_timer_chk i_chk (.clk(clk), .rst_n(rst_n), .regReq(regReq),
    .rdData(rdData), .timerOut(timerOut), .timerOutEn(timerOutEn), .matchA(matchA));
`default_nettype wire
